// File: hdl/lnb_node.sv
module lnb_node
    import lnb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] sfr_sel,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       lin_in,
    output logic            lin_out,
    output logic            lin_oe,
    output logic            lin_event
);

    function automatic logic [7:0] cks_add(input logic [7:0] a,
                                           input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        cks_add = s[7:0] + {7'h00, s[8]};
    endfunction

    function automatic logic [7:0] pid_of(input logic [5:0] id);
        pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                  id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    lnb_cfg_t   cfg_ff;
    lnb_scale_t scale_ff;
    lnb_size_t  size_ff;
    lnb_state_t state_ff;
    logic [7:0] index_ff;
    logic [7:0] div_low_ff;
    logic [5:0] id_ff;
    logic       txrx_ff;
    logic       data_req_ff;
    logic       int_req_ff;
    logic       done_ff;
    logic [2:0] err_ff;
    logic [7:0] rdata_ff;
    logic       rx_meta_ff;
    logic       rx_ff;
    logic       rx_prev_ff;
    logic [2:0] pre_cnt_ff;
    logic [8:0] div_cnt_ff;
    logic [4:0] mul_cnt_ff;
    logic [4:0] half_cnt_ff;
    logic       brk_seen_ff;
    logic       go_ff;
    logic       act_ff;
    logic       wait_start_ff;
    logic       send_ff;
    logic [4:0] hc_ff;
    logic [7:0] tx_byte_ff;
    logic [7:0] rx_sh_ff;
    logic       byte_done_ff;
    logic       bit_err_ff;
    logic       frm_err_ff;
    logic [2:0] idx_ff;
    logic [7:0] cks_ff;
    logic       tx_ff;
    logic       oe_ff;
    logic [7:0] mem_q;

    logic       win_wr;
    logic       ctl_wr;
    logic       half_tick;
    logic       restart;
    logic       rx_fall;
    logic       sw_side;
    logic [3:0] frame_len;
    logic [7:0] pid;
    logic       frame_end;
    logic       frame_abort;
    logic       byte_err;
    logic       tx_level;
    logic [2:0] rd_idx;
    logic       mem_wr;

    assign win_wr   = sfr_wr && (sfr_sel == SEL_WINDOW);
    assign ctl_wr   = win_wr && (index_ff == IDX_FRAME_CTRL);
    assign sw_side  = (state_ff == ST_IDLE) || (state_ff == ST_WAIT_ACK);
    assign pid      = pid_of(id_ff);
    assign byte_err = byte_done_ff && (bit_err_ff || frm_err_ff);
    assign rx_fall  = rx_prev_ff && !rx_ff;
    // The buffer read runs one byte ahead, since its data come a cycle late.
    assign rd_idx   = (state_ff == ST_DATA && byte_done_ff) ? idx_ff + 3'd1
                                                            : idx_ff;

    always_comb begin
        frame_len = size_ff.length;
        if (size_ff.length == LEN_FROM_ID) begin
            case (id_ff[5:4])
                2'h0:    frame_len = 4'h2;
                2'h1:    frame_len = 4'h2;
                2'h2:    frame_len = 4'h4;
                default: frame_len = 4'h8;
            endcase
        end else if (size_ff.length > LEN_MAX || size_ff.length == 4'h0) begin
            frame_len = LEN_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct registers and the indirect configuration registers.
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff   <= CFG_RESET;
            index_ff <= 8'h00;
        end else if (sfr_wr && sfr_sel == SEL_CONFIG) begin
            cfg_ff <= lnb_cfg_t'(sfr_wdata);
        end else if (sfr_wr && sfr_sel == SEL_INDEX) begin
            index_ff <= sfr_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_low_ff <= DIV_RESET;
            scale_ff   <= SCALE_RESET;
            size_ff    <= SIZE_RESET;
            txrx_ff    <= 1'b0;
        end else if (win_wr) begin
            case (index_ff)
                IDX_DIV_LOW:    div_low_ff <= sfr_wdata;
                IDX_SCALE:      scale_ff <= lnb_scale_t'(sfr_wdata);
                IDX_FRAME_SIZE: size_ff <= lnb_size_t'(sfr_wdata);
                IDX_FRAME_CTRL: txrx_ff <= sfr_wdata[CTL_TXRX];
                default:        txrx_ff <= txrx_ff;
            endcase
        end
    end

    // In slave role the received identifier overwrites the software copy.
    always_ff @(posedge clk) begin
        if (rst) begin
            id_ff <= 6'h00;
        end else if (state_ff == ST_PID && byte_done_ff && !cfg_ff.master) begin
            id_ff <= rx_sh_ff[5:0];
        end else if (win_wr && index_ff == IDX_FRAME_ID) begin
            id_ff <= sfr_wdata[5:0];
        end
    end

    // Read data is registered: it shows the selection of the previous cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (sfr_sel == SEL_CONFIG) begin
            rdata_ff <= cfg_ff;
        end else if (sfr_sel == SEL_INDEX) begin
            rdata_ff <= index_ff;
        end else if (sfr_sel == SEL_WINDOW) begin
            if (index_ff <= IDX_BUF_LAST) begin
                rdata_ff <= mem_q;
            end else begin
                case (index_ff)
                    IDX_FRAME_CTRL: rdata_ff <= {2'b00, txrx_ff, 5'h00};
                    IDX_STATUS:     rdata_ff <= {state_ff != ST_IDLE, 2'b00,
                                                 data_req_ff, int_req_ff,
                                                 |err_ff, 1'b0, done_ff};
                    IDX_ERROR:      rdata_ff <= {5'h00, err_ff};
                    IDX_FRAME_SIZE: rdata_ff <= size_ff;
                    IDX_DIV_LOW:    rdata_ff <= div_low_ff;
                    IDX_SCALE:      rdata_ff <= scale_ff;
                    IDX_FRAME_ID:   rdata_ff <= {2'b00, id_ff};
                    default:        rdata_ff <= 8'h00;
                endcase
            end
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus input synchroniser and half bit timer.
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_meta_ff <= 1'b1;
            rx_ff      <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_meta_ff <= lin_in;
            rx_ff      <= rx_meta_ff;
            rx_prev_ff <= rx_ff;
        end
    end

    // A half bit is 2^pre * divider * (mul+1) clocks, so two make one bit.
    assign half_tick = (pre_cnt_ff == (3'(1 << scale_ff.prescaler) - 3'd1))
                    && (div_cnt_ff == ({scale_ff.div_msb, div_low_ff} - 9'd1))
                    && (mul_cnt_ff == scale_ff.multiplier);
    // A break restarts the timer as well, so that it lasts whole half bits.
    assign restart = go_ff || (act_ff && wait_start_ff && rx_fall)
                  || (state_ff == ST_IDLE && cfg_ff.master
                      && ctl_wr && sfr_wdata[CTL_START]);

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            pre_cnt_ff <= 3'd0;
            div_cnt_ff <= 9'd0;
            mul_cnt_ff <= 5'd0;
        end else if (pre_cnt_ff != (3'(1 << scale_ff.prescaler) - 3'd1)) begin
            pre_cnt_ff <= pre_cnt_ff + 3'd1;
        end else begin
            pre_cnt_ff <= 3'd0;
            if (div_cnt_ff != ({scale_ff.div_msb, div_low_ff} - 9'd1)) begin
                div_cnt_ff <= div_cnt_ff + 9'd1;
            end else begin
                div_cnt_ff <= 9'd0;
                mul_cnt_ff <= half_tick ? 5'd0 : mul_cnt_ff + 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte engine: start bit, eight data bits LSB first, stop bit.
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        tx_level = 1'b1;
        if (state_ff == ST_BREAK) begin
            tx_level = 1'b0;
        end else if (act_ff && !wait_start_ff && send_ff) begin
            if (hc_ff[4:1] == 4'd0) begin
                tx_level = 1'b0;
            end else if (hc_ff[4:1] <= 4'd8) begin
                tx_level = tx_byte_ff[3'(hc_ff[4:1] - 4'd1)];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            act_ff        <= 1'b0;
            wait_start_ff <= 1'b0;
            hc_ff         <= 5'd0;
            rx_sh_ff      <= 8'h00;
            byte_done_ff  <= 1'b0;
            bit_err_ff    <= 1'b0;
            frm_err_ff    <= 1'b0;
        end else begin
            byte_done_ff <= 1'b0;
            if (go_ff) begin
                act_ff        <= 1'b1;
                wait_start_ff <= !send_ff;
                hc_ff         <= 5'd0;
                bit_err_ff    <= 1'b0;
                frm_err_ff    <= 1'b0;
            end else if (frame_abort) begin
                act_ff <= 1'b0;
            end else if (act_ff && wait_start_ff) begin
                if (rx_fall) begin
                    wait_start_ff <= 1'b0;
                end
            end else if (act_ff && half_tick) begin
                hc_ff <= hc_ff + 5'd1;
                if (!hc_ff[0]) begin
                    if (hc_ff[4:1] >= 4'd1 && hc_ff[4:1] <= 4'd8) begin
                        rx_sh_ff <= {rx_ff, rx_sh_ff[7:1]};
                    end
                    if (send_ff && rx_ff != tx_ff) begin
                        bit_err_ff <= 1'b1;
                    end
                    if (hc_ff[4:1] == 4'd9 && !rx_ff) begin
                        frm_err_ff <= 1'b1;
                    end
                end
                // A received byte ends in mid stop bit, so that a start
                // bit that follows with no gap is still seen.
                if (hc_ff == BYTE_LAST_HALF
                    || (!send_ff && hc_ff == BYTE_LAST_HALF - 5'd1)) begin
                    act_ff       <= 1'b0;
                    byte_done_ff <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer.
    ////////////////////////////////////////////////////////////////////////

    assign frame_abort = !cfg_ff.enable || (ctl_wr && sfr_wdata[CTL_STOP]);
    assign frame_end   = (state_ff == ST_CKSUM) && byte_done_ff;

    always_ff @(posedge clk) begin
        if (rst || frame_abort) begin
            state_ff    <= ST_IDLE;
            go_ff       <= 1'b0;
            send_ff     <= 1'b0;
            tx_byte_ff  <= 8'hff;
            idx_ff      <= 3'd0;
            cks_ff      <= 8'h00;
            half_cnt_ff <= 5'd0;
            brk_seen_ff <= 1'b0;
        end else begin
            go_ff <= 1'b0;
            if (go_ff) begin
                case (state_ff)
                    ST_SYNC:  tx_byte_ff <= SYNC_BYTE;
                    ST_PID:   tx_byte_ff <= pid;
                    ST_DATA:  tx_byte_ff <= mem_q;
                    ST_CKSUM: tx_byte_ff <= ~cks_ff;
                    default:  tx_byte_ff <= 8'hff;
                endcase
            end
            if (byte_err) begin
                state_ff <= ST_IDLE;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        idx_ff <= 3'd0;
                        if (cfg_ff.master) begin
                            if (ctl_wr && sfr_wdata[CTL_START]) begin
                                state_ff    <= ST_BREAK;
                                half_cnt_ff <= 5'd0;
                            end
                        end else if (rx_ff) begin
                            half_cnt_ff <= 5'd0;
                            if (brk_seen_ff) begin
                                brk_seen_ff <= 1'b0;
                                state_ff    <= ST_SYNC;
                                go_ff       <= 1'b1;
                                send_ff     <= 1'b0;
                            end
                        end else if (half_tick) begin
                            if (half_cnt_ff >= BRK_DET_HALVES) begin
                                brk_seen_ff <= 1'b1;
                            end else begin
                                half_cnt_ff <= half_cnt_ff + 5'd1;
                            end
                        end
                    end
                    ST_BREAK: begin
                        if (half_tick) begin
                            half_cnt_ff <= half_cnt_ff + 5'd1;
                            if (half_cnt_ff == BREAK_HALVES - 5'd1) begin
                                state_ff    <= ST_DELIM;
                                half_cnt_ff <= 5'd0;
                            end
                        end
                    end
                    ST_DELIM: begin
                        if (half_tick) begin
                            half_cnt_ff <= half_cnt_ff + 5'd1;
                            if (half_cnt_ff == DELIM_HALVES - 5'd1) begin
                                state_ff <= ST_SYNC;
                                go_ff    <= 1'b1;
                                send_ff  <= 1'b1;
                            end
                        end
                    end
                    ST_SYNC: begin
                        if (byte_done_ff) begin
                            state_ff <= ST_PID;
                            go_ff    <= 1'b1;
                            send_ff  <= cfg_ff.master;
                        end
                    end
                    ST_PID: begin
                        if (byte_done_ff) begin
                            cks_ff <= size_ff.enhanced ?
                                (cfg_ff.master ? pid : rx_sh_ff) : 8'h00;
                            if (cfg_ff.master) begin
                                state_ff <= ST_DATA;
                                go_ff    <= 1'b1;
                                send_ff  <= txrx_ff;
                            end else begin
                                state_ff <= ST_WAIT_ACK;
                            end
                        end
                    end
                    ST_WAIT_ACK: begin
                        if (ctl_wr && sfr_wdata[CTL_DATA_ACK]) begin
                            state_ff <= ST_DATA;
                            go_ff    <= 1'b1;
                            send_ff  <= sfr_wdata[CTL_TXRX];
                        end
                    end
                    ST_DATA: begin
                        if (byte_done_ff) begin
                            cks_ff <= cks_add(cks_ff, rx_sh_ff);
                            go_ff  <= 1'b1;
                            if ({1'b0, idx_ff} == frame_len - 4'd1) begin
                                state_ff <= ST_CKSUM;
                            end else begin
                                idx_ff <= idx_ff + 3'd1;
                            end
                        end
                    end
                    ST_CKSUM: begin
                        if (byte_done_ff) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a hardware set wins over a software clear.
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (rst) begin
            err_ff      <= 3'b000;
            int_req_ff  <= 1'b0;
            done_ff     <= 1'b0;
            data_req_ff <= 1'b0;
        end else begin
            if (ctl_wr && sfr_wdata[CTL_RST_ERR]) begin
                err_ff <= 3'b000;
            end
            if (ctl_wr && sfr_wdata[CTL_RST_INT]) begin
                int_req_ff <= 1'b0;
                done_ff    <= 1'b0;
            end
            if (ctl_wr && (sfr_wdata[CTL_DATA_ACK] || sfr_wdata[CTL_STOP])) begin
                data_req_ff <= 1'b0;
            end
            if (state_ff == ST_PID && byte_done_ff && !byte_err
                && !cfg_ff.master) begin
                data_req_ff <= 1'b1;
                int_req_ff  <= 1'b1;
            end
            if (byte_err) begin
                err_ff[ERR_BIT]     <= bit_err_ff;
                err_ff[ERR_FRAMING] <= frm_err_ff;
                int_req_ff          <= 1'b1;
            end
            if (frame_end && !byte_err) begin
                int_req_ff <= 1'b1;
                if (!send_ff && rx_sh_ff != ~cks_ff) begin
                    err_ff[ERR_CKSUM] <= 1'b1;
                end else begin
                    done_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ff <= 1'b1;
            oe_ff <= 1'b0;
        end else begin
            tx_ff <= tx_level;
            oe_ff <= !tx_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Message buffer.
    ////////////////////////////////////////////////////////////////////////

    assign mem_wr = (state_ff == ST_DATA && byte_done_ff && !send_ff)
                 || (win_wr && sw_side && index_ff <= IDX_BUF_LAST);

    lnb_msg_mem u_mem (
        .clk        (clk),
        .wr_en      (mem_wr),
        .wr_addr    (sw_side ? index_ff[2:0] : idx_ff),
        .wr_data    (sw_side ? sfr_wdata : rx_sh_ff),
        .rd_addr    (sw_side ? index_ff[2:0] : rd_idx),
        .rd_data_ff (mem_q)
    );

    assign sfr_rdata = rdata_ff;
    assign lin_out   = tx_ff;
    assign lin_oe    = oe_ff;
    assign lin_event = int_req_ff;

endmodule

// File: hdl/lnb_pkg.sv
package lnb_pkg;

    // Direct register selects on the register port.
    localparam logic [1:0] SEL_CONFIG = 2'h0;
    localparam logic [1:0] SEL_INDEX  = 2'h1;
    localparam logic [1:0] SEL_WINDOW = 2'h2;

    // Indirect register indexes.
    localparam logic [7:0] IDX_BUF_LAST   = 8'h07;
    localparam logic [7:0] IDX_FRAME_CTRL = 8'h08;
    localparam logic [7:0] IDX_STATUS     = 8'h09;
    localparam logic [7:0] IDX_ERROR      = 8'h0a;
    localparam logic [7:0] IDX_FRAME_SIZE = 8'h0b;
    localparam logic [7:0] IDX_DIV_LOW    = 8'h0c;
    localparam logic [7:0] IDX_SCALE      = 8'h0d;
    localparam logic [7:0] IDX_FRAME_ID   = 8'h0e;

    // Frame control bit positions.
    localparam int CTL_STOP     = 7;
    localparam int CTL_TXRX     = 5;
    localparam int CTL_DATA_ACK = 4;
    localparam int CTL_RST_INT  = 3;
    localparam int CTL_RST_ERR  = 2;
    localparam int CTL_START    = 0;

    // Status bit positions.
    localparam int STS_ACTIVE   = 7;
    localparam int STS_DATA_REQ = 4;
    localparam int STS_INT_REQ  = 3;
    localparam int STS_ERROR    = 2;
    localparam int STS_DONE     = 0;

    // Error bit positions.
    localparam int ERR_BIT    = 0;
    localparam int ERR_CKSUM  = 1;
    localparam int ERR_FRAMING = 2;

    // Timing in half bits.
    localparam logic [4:0] BREAK_HALVES  = 5'h1a;
    localparam logic [4:0] DELIM_HALVES  = 5'h02;
    localparam logic [4:0] BRK_DET_HALVES = 5'h16;
    localparam logic [4:0] BYTE_LAST_HALF = 5'h13;

    localparam logic [7:0] SYNC_BYTE  = 8'h55;
    localparam logic [3:0] LEN_FROM_ID = 4'hf;
    localparam logic [3:0] LEN_MAX     = 4'h8;

    typedef struct packed {
        logic       enable;
        logic       master;
        logic       auto_rate;
        logic [4:0] spare;
    } lnb_cfg_t;

    typedef struct packed {
        logic [1:0] prescaler;
        logic [4:0] multiplier;
        logic       div_msb;
    } lnb_scale_t;

    typedef struct packed {
        logic       enhanced;
        logic [2:0] spare;
        logic [3:0] length;
    } lnb_size_t;

    localparam lnb_cfg_t   CFG_RESET   = '0;
    localparam lnb_scale_t SCALE_RESET = '0;
    localparam lnb_size_t  SIZE_RESET  = '0;
    localparam logic [7:0] DIV_RESET   = 8'hc8;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_BREAK    = 4'b0001,
        ST_DELIM    = 4'b0011,
        ST_SYNC     = 4'b0010,
        ST_PID      = 4'b0110,
        ST_WAIT_ACK = 4'b0111,
        ST_DATA     = 4'b0101,
        ST_CKSUM    = 4'b0100
    } lnb_state_t;

endpackage

// File: hdl/lnb_msg_mem.sv
module lnb_msg_mem
    import lnb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data_ff
);

    logic [7:0] mem [0:7];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data_ff <= mem[rd_addr];
    end

endmodule

// File: verif/lnb_node_properties.sv
module lnb_node_properties
    import lnb_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] sfr_sel,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       lin_in,
    input wire logic       lin_out,
    input wire logic       lin_oe,
    input wire logic       lin_event
);
    logic [7:0] idx_ff;
    always_ff @(posedge clk) begin
        if (rst)
            idx_ff <= 8'h00;
        else if (sfr_wr && sfr_sel == SEL_INDEX)
            idx_ff <= sfr_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_put(logic [1:0] s, logic ok);
        ok && sfr_wr && sfr_sel == s ##1 !sfr_wr && sfr_sel == s;
    endsequence
    chk_rst_quiet: assert property (disable iff (1'b0)
        rst |=> !lin_oe && !lin_event) else $error("bus busy in reset");
    chk_oe_level: assert property (lin_oe != lin_out)
        else $error("enable and level disagree");
    chk_cfg_back: assert property (s_put(SEL_CONFIG, 1'b1)
        |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("config lost");
    chk_idx_back: assert property (s_put(SEL_INDEX, 1'b1)
        |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("index lost");
    chk_scale_back: assert property (
        s_put(SEL_WINDOW, idx_ff == IDX_SCALE)
        |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("scale lost");
    chk_none_zero: assert property (sfr_sel == 2'h3
        |=> sfr_rdata == 8'h00) else $error("empty select not zero");
    chk_unmapped_zero: assert property (
        (sfr_sel == SEL_WINDOW && idx_ff > IDX_FRAME_ID) [*2]
        |-> sfr_rdata == 8'h00) else $error("unmapped index not zero");
    chk_clear_event: assert property (sfr_wr && sfr_sel == SEL_WINDOW
        && idx_ff == IDX_FRAME_CTRL && sfr_wdata[CTL_RST_INT]
        |-> ##[1:2] !lin_event) else $error("request not cleared");
    chk_bit_min: assert property ($rose(lin_oe) |-> lin_oe [*6])
        else $error("dominant bit too short");
endmodule
bind lnb_node lnb_node_properties chk_u (.clk, .rst, .sfr_sel, .sfr_wr,
    .sfr_wdata, .sfr_rdata, .lin_in, .lin_out, .lin_oe, .lin_event);

// File: verif/lnb_peer.sv
module lnb_peer
    import lnb_pkg::*;
#(
    parameter int BIT_CYC = 8
)
(
    input  wire logic clk,
    input  wire logic lin_oe,
    output logic      lin_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    // Open drain with pull-up: recessive unless some node pulls low.
    assign lin_bus = !lin_oe && !drv;
    task automatic send(input logic [31:0] v, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(negedge clk);
            drv = !v[i];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
    endtask
    task automatic header(input logic [7:0] pid);
        send(32'h0000_0000, 13);
        send(32'h0000_0003, 2);
        send({22'h0, 1'b1, SYNC_BYTE, 1'b0}, 10);
        send({22'h0, 1'b1, pid, 1'b0}, 10);
    endtask
endmodule

// File: verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lnb_pkg::*;
    logic       clk, rst, sfr_wr, lin_out, lin_oe, lin_event, lin_bus;
    logic [1:0] sfr_sel;
    logic [7:0] sfr_wdata, sfr_rdata;
    int         failures = 0, num_checks = 0, n;
    lnb_node dut_u (.clk, .rst, .sfr_sel, .sfr_wr, .sfr_wdata, .sfr_rdata,
        .lin_in(lin_bus), .lin_out, .lin_oe, .lin_event);
    lnb_peer #(.BIT_CYC(400)) peer_u (.clk, .lin_oe, .lin_bus);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge clk);
        sfr_sel = s;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic ix(input logic [7:0] i, input logic [7:0] d);
        wr(SEL_INDEX, i);
        wr(SEL_WINDOW, d);
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        @(negedge clk);
        sfr_sel = s;
        repeat (3) @(negedge clk);
        cmp({8'h00, sfr_rdata}, {8'h00, e});
    endtask
    task automatic rdi(input logic [7:0] i, input logic [7:0] e);
        wr(SEL_INDEX, i);
        rd(SEL_WINDOW, e);
    endtask
    task automatic wait_ev;
        n = 0;
        while (lin_event !== 1'b1 && n < 29999) begin
            @(negedge clk);
            n++;
        end
        cmp({15'h0, lin_event}, 16'h0001);
    endtask
    task automatic t_regs;
        rd(SEL_CONFIG, 8'h00);
        rdi(IDX_DIV_LOW, DIV_RESET);
        rdi(IDX_SCALE, 8'h00);
        wr(SEL_WINDOW, 8'h83);
        rd(SEL_WINDOW, 8'h83);
        wr(SEL_CONFIG, 8'ha0);
        rd(SEL_CONFIG, 8'ha0);
        rdi(8'h3f, 8'h00);
        rd(2'h3, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_master(input logic [7:0] sc, input int h, input bit full);
        wr(SEL_CONFIG, 8'hc0);
        ix(IDX_SCALE, sc);
        ix(IDX_DIV_LOW, 8'hc8);
        ix(IDX_FRAME_ID, 8'h11);
        ix(IDX_FRAME_SIZE, 8'h81);
        ix(8'h00, 8'ha5);
        ix(IDX_FRAME_CTRL, 8'h21);
        n = 0;
        while (lin_oe !== 1'b1 && n < 99) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (lin_oe === 1'b1) begin
            @(negedge clk);
            n++;
        end
        cmp(n[15:0], 16'(26 * h));
        if (full) begin
            wait_ev;
            rdi(IDX_STATUS, 8'h09);
        end else begin
            ix(IDX_FRAME_CTRL, 8'h80);
        end
        ix(IDX_FRAME_CTRL, 8'h0c);
        rdi(IDX_STATUS, 8'h00);
        cmp({15'h0, lin_event}, 16'h0000);
        $display("t_master done");
    endtask
    task automatic t_slave;
        wr(SEL_CONFIG, 8'h80);
        ix(IDX_SCALE, 8'h00);
        peer_u.header(8'h11);
        wait_ev;
        rdi(IDX_ERROR, 8'h00);
        rdi(IDX_FRAME_ID, 8'h11);
        ix(IDX_FRAME_CTRL, 8'h8c);
        rdi(IDX_STATUS, 8'h00);
        $display("t_slave done");
    endtask
    task automatic end_of_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        sfr_sel = 2'h0;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_regs;
        t_master(8'h00, 200, 1'b1);
        t_master(8'h42, 800, 1'b0);
        t_slave;
        end_of_test;
    end
    initial begin
        #600000;
        failures++;
        end_of_test;
    end
endmodule
